// >>> core/anm_map.vh
`ifndef ANM_MAP_VH
`define ANM_MAP_VH

// Register indices and byte addresses (byte address is four times the index)
`define ANM_IDX_CTRL        8'h00
`define ANM_IDX_BSTAT       8'h01
`define ANM_IDX_CFG         8'h10
`define ANM_IDX_FPSTAT      8'h11
`define ANM_ADDR_CTRL       8'h00
`define ANM_ADDR_BSTAT      8'h04
`define ANM_ADDR_CFG        8'h40
`define ANM_ADDR_FPSTAT     8'h44

// Control register fields
`define ANM_CTRL_RESTART    9
`define ANM_CTRL_ENABLE     12
// Basic status register fields
`define ANM_BSTAT_LINK      2
`define ANM_BSTAT_DONE      5
// Configuration register fields
`define ANM_CFG_HWMODE      0
`define ANM_CFG_SLOW        8
// Fast-poll status register fields
`define ANM_FP_LINK         0
`define ANM_FP_DONE         4
`define ANM_FP_MON_LO       11
`define ANM_FP_MON_HI       13
`define ANM_FP_DUPLEX       14
`define ANM_FP_RATE         15

// Reset values
`define ANM_CTRL_ENABLE_RST 1'b1
`define ANM_CFG_HWMODE_RST  1'b0
`define ANM_PROG_RST        4'h0

// Progress codes
`define ANM_CODE_MAX        4'h8
`define ANM_CODE_DONE       4'hf
`define ANM_CODE_LINKED     4'h8

// AXI responses
`define ANM_RESP_OKAY       2'b00
`define ANM_RESP_SLVERR     2'b10

// Timing
`define ANM_CLK_KHZ         25000
`define ANM_AN_TIME_MS      500
`define ANM_AN_TIME_CYC     (`ANM_AN_TIME_MS * `ANM_CLK_KHZ)

`endif

// >>> core/anm_sync.v
`timescale 1ns/1ps
`default_nettype none

module anm_sync #(
    parameter WIDTH = 2
) (
    // Clock and reset
    input  wire             clk,
    input  wire             arst_n,
    // Asynchronous inputs
    input  wire [WIDTH-1:0] async_in,
    // Filtered outputs
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;
    integer         i;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q     <= {WIDTH{1'b0}};
            s2_q     <= {WIDTH{1'b0}};
            s3_q     <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // A change counts only once stages two and three agree
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_out[i] <= s3_q[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

// >>> core/anm_top.v
`timescale 1ns/1ps
`default_nettype none

`include "anm_map.vh"

// Functional notes
// [R1] Restart resets arbitration and monitor but keeps progress status bits.
// [R2] After restart, status changes only by read, reset, or higher arbitration state.
// [R3] Progress bits load arbitration state only when it exceeds stored value.
// [R4] After completion code, only fast-poll read or reset alters progress bits.
// [R5] A link failure starts a restart.
// [R6] Software mode: writing one to restart bit restarts; bit clears itself.
// [R7] Software mode: enable bit going one, zero, one restarts.
// [R8] Hardware mode: select pin going high, low, high restarts.
// [R9] Negotiation normally finishes within 500 ms; slow attempts are flagged.
// [R10] Management polls completion and link status bits to see link up.
// [R11] Fast-poll register shows resolved speed and duplex.
// [R12] Fast-poll register copies link status and completion bits.
// [R13] Four-bit progress code: completion bit on top, then three monitor bits.
// [R14] Progress code is 0h to 8h or Fh.
// [R15] Each fast-poll read loads current arbitration state unconditionally.
// [R16] A read returns the status stored before that read.
// [R17] Management reads twice: highest state first, current state second.
// [R18] First read after completion returns completion one, monitor bits 111.
// [R19] Later reads with link up return completion one, monitor bits 000.
// [R20] Any reset idles arbitration and clears all progress bits.
// [R21] Completion sets completion bit in basic and fast-poll registers.
// [R22] Link fault clears link bit in basic and fast-poll registers.
// [R23] Read-triggered load happens after the read data are captured.
module anm_top #(
    parameter AN_TIMEOUT_CYC = `ANM_AN_TIME_CYC
) (
    // Clock and reset
    input  wire        clk,
    input  wire        arst_n,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Pins
    input  wire        autoneg_select_pin,
    input  wire        link_ok_pin,
    // Arbitration state machine side
    input  wire [3:0]  arb_state,
    input  wire        res_speed_100,
    input  wire        res_full_duplex,
    output reg         an_restart,
    output reg         an_enable
);

    // Synchronised pins
    wire [1:0] pins_s;
    wire       sel_s;
    wire       link_s;

    anm_sync #(
        .WIDTH    (2)
    ) u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in ({link_ok_pin, autoneg_select_pin}),
        .sync_out (pins_s)
    );

    assign sel_s  = pins_s[0];
    assign link_s = pins_s[1];

    // Registers
    reg        ctrl_en_q;
    reg        ctrl_restart_q;
    reg        cfg_hw_q;
    reg        slow_q;
    reg  [3:0] prog_q;
    reg        held_q;
    reg        link_prev_q;
    reg        sel_prev_q;
    reg        en_prev_q;
    reg        armed_q;
    reg  [23:0] tmr_q;

    // Write channel state
    reg        aw_have_q;
    reg        w_have_q;
    reg  [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg  [3:0] w_strb_q;

    wire       do_write;
    wire       rd_take;
    wire       rd_fpstat;
    wire       link_fail;
    wire       sel_rise;
    wire       en_rise;
    wire       restart_req;
    wire       an_done;
    wire [3:0] load_code;

    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `ANM_ADDR_CTRL) || (a == `ANM_ADDR_BSTAT) ||
                        (a == `ANM_ADDR_CFG) || (a == `ANM_ADDR_FPSTAT);
        end
    endfunction

    // Codes outside 0h..8h and Fh are never stored
    function [3:0] legal_code;
        input [3:0] c;
        begin
            if ((c <= `ANM_CODE_MAX) || (c == `ANM_CODE_DONE)) begin
                legal_code = c; // [R14]
            end else begin
                legal_code = `ANM_CODE_MAX;
            end
        end
    endfunction

    assign do_write  = aw_have_q && w_have_q && !s_axi_bvalid;
    assign rd_take   = s_axi_arvalid && s_axi_arready;
    assign rd_fpstat = rd_take && (s_axi_araddr == `ANM_ADDR_FPSTAT);
    assign an_done   = (arb_state == `ANM_CODE_DONE);
    assign link_fail = link_prev_q && !link_s; // [R5]
    // High, low, high: rise after a fall seen from a high level
    assign sel_rise  = cfg_hw_q && !sel_prev_q && sel_s; // [R8]
    assign en_rise   = !cfg_hw_q && !en_prev_q && ctrl_en_q; // [R7]
    assign restart_req = link_fail || sel_rise || en_rise ||
                         (!cfg_hw_q && ctrl_restart_q); // [R6]
    // Completed and linked reads back as completion with monitor bits 000
    assign load_code = (an_done && link_s) ? `ANM_CODE_LINKED :
                       legal_code(arb_state); // [R19]

    // Write address and data, taken in either order
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `ANM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q     <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q     <= 1'b1;
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(aw_addr_q) ? `ANM_RESP_OKAY : `ANM_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Control and configuration registers
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_en_q      <= `ANM_CTRL_ENABLE_RST;
            ctrl_restart_q <= 1'b0;
            cfg_hw_q       <= `ANM_CFG_HWMODE_RST;
        end else begin
            // Self-clearing; a new write in the clearing cycle still sets it
            ctrl_restart_q <= 1'b0; // [R6]
            if (do_write && (aw_addr_q == `ANM_ADDR_CTRL) && w_strb_q[1]) begin
                ctrl_en_q      <= w_data_q[`ANM_CTRL_ENABLE];
                ctrl_restart_q <= w_data_q[`ANM_CTRL_RESTART]; // [R6]
            end
            if (do_write && (aw_addr_q == `ANM_ADDR_CFG) && w_strb_q[0]) begin
                cfg_hw_q <= w_data_q[`ANM_CFG_HWMODE];
            end
        end
    end

    // Edge history and restart pulse
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link_prev_q <= 1'b0;
            sel_prev_q  <= 1'b1;
            en_prev_q   <= `ANM_CTRL_ENABLE_RST;
            an_restart  <= 1'b0;
            an_enable   <= 1'b0;
        end else begin
            link_prev_q <= link_s;
            sel_prev_q  <= sel_s;
            en_prev_q   <= ctrl_en_q;
            // Restart idles the arbitration side and clears the slow watch; progress bits untouched
            an_restart  <= restart_req; // [R1] [R5] [R7] [R8]
            an_enable   <= cfg_hw_q ? sel_s : ctrl_en_q;
        end
    end

    // Progress monitor latch
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_q <= `ANM_PROG_RST; // [R20]
            held_q <= 1'b0;
        end else begin
            // Once read while complete, hold until arbitration leaves completion
            held_q <= an_done && (rd_fpstat || held_q); // [R4] [R19]
            if (rd_fpstat) begin
                // Read data are captured from the old value on this same edge
                prog_q <= load_code; // [R15] [R16] [R23] [R17]
            end else if ((prog_q == `ANM_CODE_DONE) || held_q) begin
                prog_q <= prog_q; // [R4] [R19]
            end else if (legal_code(arb_state) > prog_q) begin
                prog_q <= legal_code(arb_state); // [R2] [R3] [R18]
            end
        end
    end

    // Slow negotiation watch, cleared by every restart
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tmr_q   <= 24'h000000;
            armed_q <= 1'b1;
            slow_q  <= 1'b0;
        end else if (an_restart) begin
            tmr_q   <= 24'h000000;
            armed_q <= 1'b1;
            slow_q  <= 1'b0;
        end else if (armed_q) begin
            if (an_done) begin
                armed_q <= 1'b0;
            end else if (tmr_q == AN_TIMEOUT_CYC[23:0] - 24'h000001) begin
                slow_q  <= 1'b1; // [R9]
                armed_q <= 1'b0;
            end else begin
                tmr_q <= tmr_q + 24'h000001;
            end
        end
    end

    // Read channel
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `ANM_RESP_OKAY;
        end else begin
            if (rd_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `ANM_RESP_OKAY;
                s_axi_rdata   <= 32'h00000000;
                if (s_axi_araddr == `ANM_ADDR_CTRL) begin
                    s_axi_rdata[`ANM_CTRL_ENABLE]  <= ctrl_en_q;
                    s_axi_rdata[`ANM_CTRL_RESTART] <= ctrl_restart_q;
                end else if (s_axi_araddr == `ANM_ADDR_BSTAT) begin
                    s_axi_rdata[`ANM_BSTAT_DONE] <= an_done; // [R21] [R10]
                    s_axi_rdata[`ANM_BSTAT_LINK] <= link_s; // [R22]
                end else if (s_axi_araddr == `ANM_ADDR_CFG) begin
                    s_axi_rdata[`ANM_CFG_HWMODE] <= cfg_hw_q;
                    s_axi_rdata[`ANM_CFG_SLOW]   <= slow_q;
                end else if (s_axi_araddr == `ANM_ADDR_FPSTAT) begin
                    s_axi_rdata[`ANM_FP_RATE]   <= res_speed_100; // [R11]
                    s_axi_rdata[`ANM_FP_DUPLEX] <= res_full_duplex; // [R11]
                    s_axi_rdata[`ANM_FP_MON_HI:`ANM_FP_MON_LO] <= prog_q[2:0]; // [R13] [R16]
                    s_axi_rdata[`ANM_FP_DONE]   <= prog_q[3]; // [R12] [R21] [R13]
                    s_axi_rdata[`ANM_FP_LINK]   <= link_s; // [R12] [R22]
                end else begin
                    s_axi_rresp <= `ANM_RESP_SLVERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> core/anm_unused_placeholder_never.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> tb/anm_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module anm_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        arst_n,
    // Register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    // Pins and arbitration side
    input wire logic        link_ok_pin,
    input wire logic [3:0]  arb_state,
    input wire logic        res_speed_100,
    input wire logic        res_full_duplex,
    input wire logic        an_restart,
    input wire logic        an_enable
);
    logic [3:0] pg_q, ex_q;
    logic [2:0] sd_q;
    logic       rf_q, fp_q, bs_q, hw_q, lk_q;
    wire        ar_t = s_axi_arvalid && s_axi_arready;
    wire        wr_t = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire        big  = arb_state > 4'h8 && arb_state != 4'hf;
    wire [3:0]  up   = big ? 4'h8 : arb_state;
    // Link assumed settled around reads; pin stands in for the synced copy
    wire [3:0]  cur  = (arb_state == 4'hf && link_ok_pin) ? 4'h8 : up;
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {pg_q, ex_q, sd_q, rf_q, fp_q, bs_q, hw_q, lk_q} <= '0;
        end else begin
            if (ar_t) begin
                ex_q <= pg_q;
                fp_q <= s_axi_araddr == 8'h44;
                bs_q <= s_axi_araddr == 8'h04;
                lk_q <= link_ok_pin;
                sd_q <= {res_speed_100, res_full_duplex, arb_state == 4'hf};
            end
            if (arb_state != 4'hf) rf_q <= 1'b0;
            if (ar_t && s_axi_araddr == 8'h44) begin
                pg_q <= cur;
                rf_q <= arb_state == 4'hf;
            end else if (pg_q != 4'hf && !rf_q && up > pg_q) begin
                pg_q <= up;
            end
            if (wr_t && s_axi_awaddr == 8'h40) hw_q <= s_axi_wdata[0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    prog_read_a: assert property ($rose(s_axi_rvalid) && fp_q
        |-> {s_axi_rdata[4], s_axi_rdata[13:11]} == ex_q) else $error("progress code mismatch");
    code_range_a: assert property ($rose(s_axi_rvalid) && fp_q
        |-> s_axi_rdata[4] ? s_axi_rdata[13:11] inside {3'h0, 3'h7} : 1'b1) else $error("bad code");
    rate_dup_a: assert property ($rose(s_axi_rvalid) && fp_q
        |-> s_axi_rdata[15:14] == sd_q[2:1]) else $error("rate or duplex wrong");
    fp_link_a: assert property ($rose(s_axi_rvalid) && fp_q
        |-> s_axi_rdata[0] == lk_q) else $error("fast poll link wrong");
    basic_stat_a: assert property ($rose(s_axi_rvalid) && bs_q
        |-> s_axi_rdata[5] == sd_q[0] && s_axi_rdata[2] == lk_q) else $error("basic status wrong");
    link_fail_a: assert property (link_ok_pin [*6] ##1 !link_ok_pin
        |-> ##[1:8] an_restart) else $error("no restart on link loss");
    en_toggle_a: assert property ($rose(an_enable) && $past(arst_n, 2)
        |-> ##[0:2] an_restart) else $error("no restart on enable toggle");
    sw_restart_a: assert property (wr_t && s_axi_awaddr == 8'h00 && s_axi_wdata[9] && !hw_q
        |-> ##[1:3] an_restart) else $error("no restart on restart bit");
    cover property ($rose(an_restart));
    cover property ($rose(s_axi_rvalid) && fp_q && ex_q == 4'hf);
    cover property ($rose(s_axi_rvalid) && bs_q && sd_q[0]);
endmodule
bind anm_top anm_chk u_chk (.*);
`default_nettype wire

// >>> tb/anm_mgr.sv
`timescale 1ns/1ps
`default_nettype none
module anm_mgr (
    // Clock
    input  wire logic        clk,
    // Write channels
    output var  logic [7:0]  s_axi_awaddr,
    output var  logic        s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output var  logic [31:0] s_axi_wdata,
    output var  logic [3:0]  s_axi_wstrb,
    output var  logic        s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output var  logic        s_axi_bready,
    // Read channels
    output var  logic [7:0]  s_axi_araddr,
    output var  logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output var  logic        s_axi_rready,
    // Hang flag
    output var  logic        tmo
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, tmo} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        bit dn;
        dn = 0;
        r = 2'b11;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 64 && !dn; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                dn = 1;
            end
        end
        if (!dn) tmo <= 1'b1;
    endtask
    // Fast-poll reads have side effects, so callers read singly or in pairs
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        bit dn;
        dn = 0;
        r = 2'b11;
        d = '0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 64 && !dn; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                dn = 1;
            end
        end
        if (!dn) tmo <= 1'b1;
    endtask
endmodule
`default_nettype wire

// >>> tb/autoneg_restart_progress_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module autoneg_restart_progress_monitor_tb;
    logic        clk = 1'b0;
    logic        arst_n, autoneg_select_pin, link_ok_pin, res_speed_100, res_full_duplex;
    logic [3:0]  arb_state, s_axi_wstrb;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        an_restart, an_enable, tmo;
    int          err_count = 0, n_checks = 0, rc = 0;
    localparam logic [31:0] M = 32'h0000_3810;
    // Short timeout keeps the slow-attempt flag reachable in a short run
    anm_top #(.AN_TIMEOUT_CYC(50)) u_dut (.*);
    anm_mgr u_mgr (.*);
    always #20 clk = ~clk;
    always @(posedge clk) if (an_restart === 1'b1) rc++;
    always @(posedge tmo) begin
        err_count++;
        results();
    end
    function automatic logic [31:0] pc(input logic [3:0] c);
        pc = ({29'h0, c[2:0]} << 11) | ({31'h0, c[3]} << 4);
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic st(input logic [3:0] a, input int n);
        arb_state <= a;
        w(n);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        u_mgr.rd(a, d, r);
        chk(d & m, e);
    endtask
    task automatic results;
        $display("checks=%0d mismatches=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {arst_n, link_ok_pin, res_speed_100, res_full_duplex, arb_state} = '0;
        autoneg_select_pin = 1'b1;
        w(20);
        arst_n <= 1'b1;
        w(60);
        rdc(8'h44, M, 32'h0);
        rdc(8'h00, 32'h1200, 32'h1000);
        rdc(8'h40, 32'h101, 32'h100);
        u_mgr.rd(8'h08, d, r);
        chk(r, 2'b10);
        $display("test reset done");
        st(4'h3, 4);
        st(4'h1, 4);
        rdc(8'h44, M, pc(4'h3));
        rdc(8'h44, M, pc(4'h1));
        st(4'h5, 4);
        rdc(8'h44, M, pc(4'h5));
        $display("test progress done");
        st(4'h2, 4);
        u_mgr.wr(8'h00, 32'h1200, r);
        chk(r, 2'b00);
        w(6);
        chk(rc, 1);
        rdc(8'h00, 32'h200, 32'h0);
        st(4'h4, 4);
        rdc(8'h44, M, pc(4'h5));
        $display("test restart bit done");
        u_mgr.wr(8'h00, 32'h0, r);
        w(2);
        chk({31'h0, an_enable}, 32'h0);
        u_mgr.wr(8'h00, 32'h1000, r);
        w(6);
        chk(rc, 2);
        u_mgr.wr(8'h40, 32'h1, r);
        autoneg_select_pin <= 1'b0;
        w(8);
        autoneg_select_pin <= 1'b1;
        w(8);
        chk(rc, 3);
        u_mgr.wr(8'h40, 32'h0, r);
        $display("test toggles done");
        link_ok_pin <= 1'b1;
        w(10);
        link_ok_pin <= 1'b0;
        w(10);
        chk(rc, 4);
        rdc(8'h04, 32'h4, 32'h0);
        rdc(8'h44, 32'h1, 32'h0);
        $display("test link fail done");
        link_ok_pin <= 1'b1;
        res_speed_100 <= 1'b1;
        st(4'hf, 10);
        st(4'h2, 4);
        st(4'hf, 4);
        rdc(8'h04, 32'h24, 32'h24);
        rdc(8'h44, 32'hf811, 32'hb811);
        res_full_duplex <= 1'b1;
        rdc(8'h44, 32'hf811, 32'hc011);
        $display("test completion done");
        // Progress bits hold 8h here; a reset in mid-run must clear them
        st(4'h0, 2);
        arst_n <= 1'b0;
        w(2);
        arst_n <= 1'b1;
        w(4);
        rdc(8'h44, M, 32'h0);
        $display("test mid-run reset done");
        results();
    end
endmodule
`default_nettype wire
